// file: rtl/adc_scan_defs.vh
/*
 header of constants for the converter scan and bus supply monitor.
 assumes a 100 MHz mclk; included by its bare name.
*/
`ifndef ADC_SCAN_DEFS_VH
`define ADC_SCAN_DEFS_VH

`define CLK_HZ 100000000
// trigger rate in millihertz: 4.854 kHz
`define TRIG_MHZ 4854000
// cycles per trigger: clock over rate, rounded down
`define TRIG_CYC ((`CLK_HZ * 64'd1000) / `TRIG_MHZ)
`define RES_W 10
`define NUM_CH 3
// scan slots: jack one, bus supply, jack two
`define SLOT_JACK1 2'h0
`define SLOT_VBUS 2'h1
`define SLOT_JACK2 2'h2
// mux selects of the analogue front end
`define MUX_CH0 4'h0
`define MUX_CH9 4'h9
`define MUX_CH11 4'hB
`define JACK_5V_CODE 10'd206
`define JACK_0V_CODE 10'd989
`define VBUS_FULL_CODE 10'd1023
`define VBUS_5V_CODE 10'd775
`define SHORT_CODE 10'h22E
`define RECOVER_CODE 10'h26C
`define SHORT_MS 100
`define RECOVER_MS 1000
`define SHORT_CYC (`SHORT_MS * (`CLK_HZ / 1000))
`define RECOVER_CYC (`RECOVER_MS * (`CLK_HZ / 1000))

`endif

// file: rtl/edge_comparator.v
/*
 one comparator channel: inverted-sense output status and a falling-pin
 edge pulse. assumes the comparator result is synchronous to mclk.
*/
`timescale 1ns/10ps
module edge_comparator (
  input wire mclk,
  input wire rst_b,
  input wire pin_above_ref,
  output reg comparator_output_bit,
  output reg edge_irq
);
  reg pin_q;

  always @(posedge mclk) begin
    if (!rst_b) begin
      pin_q <= 1'b1;
      comparator_output_bit <= 1'b0;
      edge_irq <= 1'b0;
    end else begin
      pin_q <= pin_above_ref;
      // invert to undo the inverting jack buffer
      comparator_output_bit <= ~pin_above_ref;
      // falling pin edge only; the status recheck drops the other edge
      edge_irq <= pin_q & ~pin_above_ref;
    end
  end
endmodule // edge_comparator

// file: rtl/adc_scan_vbus_monitor.v
/*
 converter scan sequencer, result holding, bus supply short monitor and
 jack comparators. assumes one shared converter outside: conv_start
 begins a conversion of the channel on adc_mux, conv_done pulses once
 with conv_data valid. all inputs synchronous to mclk.
*/
// Contract
// - one shared converter gives unsigned ten-bit results for all channels.
// - the sequencer steps the channel list, buffers results, interrupts when full.
// - the list order is jack one, bus supply, then jack two, repeating.
// - a timer triggers at 4.854 kHz and each trigger converts the next channel.
// - each channel and the results interrupt run at a third of that rate.
// - on each results interrupt the three results go to holding values.
// - jack codes are inverted, 206 at five volts and 989 at zero volts.
// - bus supply maps code zero to 1023 linearly, five volts reads 775.
// - a short is declared after every bus reading stays at or below 558 for 100 ms.
// - after a short all else halts until 620 or more holds 1000 ms, then reset; here only results stop, conversions keep running.
// - comparators run all the time alongside the scan and raise interrupts.
// - jack one feeds comparator three and comparator two is unused.
// - jack two feeds comparator one.
// - comparators invert so their output follows the jack voltage.
// - comparator interrupts fire on pin falling edges, checked by status.
// - each comparator output is readable as a status bit.
`timescale 1ns/10ps
`include "adc_scan_defs.vh"
module adc_scan_vbus_monitor #(
  parameter TRIG_CYCLES = `TRIG_CYC,
  parameter SHORT_CYCLES = `SHORT_CYC,
  parameter RECOVER_CYCLES = `RECOVER_CYC
) (
  input wire mclk,
  input wire rst_b,
  output reg conv_start,
  output reg [3:0] adc_mux,
  input wire conv_done,
  input wire [9:0] conv_data,
  input wire cmp1_pin_above_ref,
  input wire cmp3_pin_above_ref,
  output reg [9:0] jack_one_result,
  output reg [9:0] jack_two_result,
  output reg [9:0] bus_supply_result,
  output reg results_irq,
  output wire jack_one_status,
  output wire jack_two_status,
  output wire jack_one_irq,
  output wire jack_two_irq,
  output reg short_halt,
  output reg self_reset_req
);
  localparam ST_RUN = 2'h0;
  localparam ST_HALT = 2'h1;
  localparam ST_RESET = 2'h2;

  reg [31:0] trig_cnt_q;
  reg [1:0] slot_q;
  reg busy_q;
  // jack two goes straight to its holding value, so two words suffice
  reg [9:0] buf_q [0:1];
  reg vbus_low_q;
  reg vbus_good_q;
  reg [31:0] qual_cnt_q;
  reg [1:0] state_q;
  wire trig;
  wire is_short;
  wire is_ok;
  wire vbus_done;
  wire conv_accept;
  wire start_ok;
  wire scan_wrap;
  wire scan_run;

  assign trig = (trig_cnt_q == TRIG_CYCLES - 1);
  assign conv_accept = conv_done && busy_q;
  assign start_ok = trig && !busy_q && (state_q != ST_RESET);
  assign scan_wrap = conv_accept && (slot_q == `SLOT_JACK2);
  assign scan_run = (state_q == ST_RUN);
  assign vbus_done = conv_accept && (slot_q == `SLOT_VBUS);
  assign is_short = conv_data <= `SHORT_CODE;
  assign is_ok = conv_data >= `RECOVER_CODE;

  // trigger timer keeps counting; halting only masks result updates
  always @(posedge mclk) begin
    if (!rst_b || trig) begin
      trig_cnt_q <= 32'h0;
    end else begin
      trig_cnt_q <= trig_cnt_q + 32'h1;
    end
  end

  // conversion start: one pulse per trigger, skipped while one is pending or once self reset is requested;
  // the bus slot keeps running in halt so recovery can be seen
  always @(posedge mclk) begin
    if (!rst_b) begin
      conv_start <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      conv_start <= start_ok;
      if (start_ok) begin
        busy_q <= 1'b1;
      end else if (conv_accept) begin
        busy_q <= 1'b0;
      end
    end
  end

  // channel select follows the slot taken at the start
  always @(posedge mclk) begin
    if (!rst_b) begin
      adc_mux <= `MUX_CH0;
    end else if (start_ok) begin
      case (slot_q)
        `SLOT_JACK1: adc_mux <= `MUX_CH0;
        `SLOT_VBUS: adc_mux <= `MUX_CH9;
        `SLOT_JACK2: adc_mux <= `MUX_CH11;
        default: adc_mux <= `MUX_CH0;
      endcase
    end
  end

  // slot pointer moves on each accepted result, wraps after jack two
  always @(posedge mclk) begin
    if (!rst_b) begin
      slot_q <= `SLOT_JACK1;
    end else if (scan_wrap) begin
      slot_q <= `SLOT_JACK1;
    end else if (conv_accept) begin
      slot_q <= slot_q + 2'h1;
    end
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      buf_q[0] <= 10'h0;
      buf_q[1] <= 10'h0;
    end else if (conv_accept && !scan_wrap) begin
      buf_q[slot_q[0]] <= conv_data;
    end
  end

  // results frozen while halted; raw codes kept, jacks inverted and
  // bus linear so scaling is left to whoever reads them
  always @(posedge mclk) begin
    if (!rst_b) begin
      results_irq <= 1'b0;
      jack_one_result <= 10'h0;
      jack_two_result <= 10'h0;
      bus_supply_result <= 10'h0;
    end else begin
      // buffer full once per three triggers
      results_irq <= scan_wrap && scan_run;
      if (scan_wrap && scan_run) begin
        jack_one_result <= buf_q[0];
        bus_supply_result <= buf_q[1];
        jack_two_result <= conv_data;
      end
    end
  end

  // side of the latest bus reading; a span only counts from the first
  // reading on the new side, so it is never shorter than asked
  always @(posedge mclk) begin
    if (!rst_b) begin
      vbus_low_q <= 1'b0;
      vbus_good_q <= 1'b0;
    end else if (vbus_done) begin
      vbus_low_q <= is_short;
      vbus_good_q <= is_ok;
    end
  end

  // short monitor: qualifying counter restarts on any opposing reading
  always @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      qual_cnt_q <= 32'h0;
      short_halt <= 1'b0;
      self_reset_req <= 1'b0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (vbus_done && !is_short) begin
            qual_cnt_q <= 32'h0;
          end else if (vbus_low_q && qual_cnt_q >= SHORT_CYCLES - 1) begin
            qual_cnt_q <= 32'h0;
            state_q <= ST_HALT;
            short_halt <= 1'b1;
          end else if (vbus_low_q) begin
            qual_cnt_q <= qual_cnt_q + 32'h1;
          end else begin
            qual_cnt_q <= 32'h0;
          end
        end
        ST_HALT: begin
          if (vbus_done && !is_ok) begin
            qual_cnt_q <= 32'h0;
          end else if (vbus_good_q && qual_cnt_q >= RECOVER_CYCLES - 1) begin
            state_q <= ST_RESET;
            self_reset_req <= 1'b1;
          end else if (vbus_good_q) begin
            qual_cnt_q <= qual_cnt_q + 32'h1;
          end else begin
            qual_cnt_q <= 32'h0;
          end
        end
        ST_RESET: begin
          self_reset_req <= 1'b1;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // comparators run regardless of scan state
  edge_comparator u_cmp3 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_above_ref(cmp3_pin_above_ref),
    .comparator_output_bit(jack_one_status),
    .edge_irq(jack_one_irq)
  );

  edge_comparator u_cmp1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_above_ref(cmp1_pin_above_ref),
    .comparator_output_bit(jack_two_status),
    .edge_irq(jack_two_irq)
  );
endmodule // adc_scan_vbus_monitor

// file: verification/adc_scan_properties.sv
/*
 port checker of the scan monitor.
 assumes one clock domain and short count parameters.
*/
`timescale 1ns/10ps
module adc_scan_properties (
  input wire mclk, rst_b, conv_start, results_irq, short_halt,
  input wire self_reset_req, cmp1_pin_above_ref, cmp3_pin_above_ref,
  input wire jack_one_status, jack_two_status, jack_one_irq, jack_two_irq,
  input wire [3:0] adc_mux,
  input wire [9:0] jack_one_result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  mux_list_a: assert property (
    conv_start |-> adc_mux inside {4'h0, 4'h9, 4'hB}) else $error("mux");
  start_pulse_a: assert property (
    conv_start |=> !conv_start) else $error("start width");
  irq_pulse_a: assert property (
    results_irq |=> !results_irq) else $error("irq width");
  hold_value_a: assert property (
    !results_irq |-> $stable(jack_one_result)) else $error("result moved");
  halt_stay_a: assert property (
    short_halt |=> short_halt) else $error("halt dropped");
  reset_after_a: assert property (
    self_reset_req |-> short_halt) else $error("reset without halt");
  status_sense_a: assert property (
    !cmp3_pin_above_ref [*3] |-> jack_one_status) else $error("sense");
  edge_fire_a: assert property (
    $past(rst_b, 2) && $fell(cmp1_pin_above_ref) |-> ##[0:2] jack_two_irq)
    else $error("edge missed");
  edge_sense_a: assert property (
    jack_two_irq |-> jack_two_status) else $error("wrong edge");
  fire_one_a: assert property (
    $fell(cmp3_pin_above_ref) |=> jack_one_irq) else $error("edge one missed");
  edge_one_a: assert property (
    jack_one_irq |-> jack_one_status) else $error("wrong edge one");
  reset_stay_a: assert property (
    self_reset_req |=> self_reset_req) else $error("reset request dropped");
  cover property (jack_one_irq);
  cover property (results_irq);
  cover property (short_halt);
  cover property (self_reset_req);
endmodule // adc_scan_properties
bind adc_scan_vbus_monitor adc_scan_properties i_chk (.*);

// file: verification/conv_model.sv
/*
 shared converter model: answers each start three cycles later.
 assumes starts come on mclk; codes per channel set by the bench.
*/
`timescale 1ns/10ps
module conv_model (
  input wire mclk, conv_start,
  input wire [3:0] adc_mux,
  input wire [9:0] code_j1, code_vb, code_j2,
  output reg conv_done = 1'b0,
  output reg [9:0] conv_data = 10'h0
);
  reg [3:0] mux_q = 4'h0;
  reg [1:0] wait_q = 2'h0;
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    // stale data is scrambled so a late sample cannot pass by luck
    conv_data <= ~conv_data;
    if (conv_start) begin
      mux_q <= adc_mux;
      wait_q <= 2'h3;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h1) begin
        conv_done <= 1'b1;
        conv_data <= mux_q == 4'h0 ? code_j1 :
          mux_q == 4'h9 ? code_vb : code_j2;
      end
    end
  end
endmodule // conv_model

// file: verification/tb_adc_scan_vbus_monitor.sv
/*
 bench of the scan monitor with the converter model.
 assumes short counts: trigger 20, short 200, recovery 500 cycles.
*/
`timescale 1ns/10ps
module tb_adc_scan_vbus_monitor;
  reg mclk = 1'b0, rst_b = 1'b0, p1 = 1'b1, p3 = 1'b1;
  reg [9:0] j1 = 10'h0, vb = 10'h0, j2 = 10'h0;
  reg [31:0] seed = 32'h9F8705A0;
  wire done, start, r_irq, s1, s2, halt, sreq;
  wire [3:0] mux;
  wire [9:0] data, r1, r2, rv;
  logic [29:0] exp_q[$];
  integer num_errors = 0, checked = 0, n = 0, k;
  always #5 mclk = ~mclk;
  adc_scan_vbus_monitor #(.TRIG_CYCLES(20), .SHORT_CYCLES(200),
    .RECOVER_CYCLES(500)) i_dut (.mclk(mclk), .rst_b(rst_b),
    .conv_start(start), .adc_mux(mux), .conv_done(done), .conv_data(data),
    .cmp1_pin_above_ref(p1), .cmp3_pin_above_ref(p3),
    .jack_one_result(r1), .jack_two_result(r2), .bus_supply_result(rv),
    .results_irq(r_irq), .jack_one_status(s1), .jack_two_status(s2),
    .jack_one_irq(), .jack_two_irq(), .short_halt(halt),
    .self_reset_req(sreq));
  conv_model i_conv (.mclk(mclk), .conv_start(start), .adc_mux(mux),
    .code_j1(j1), .code_vb(vb), .code_j2(j2), .conv_done(done),
    .conv_data(data));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task cmp(input [31:0] got, input [31:0] want);
    checked = checked + 1;
    if (got !== want) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task end_of_test;
    // an expectation never taken off means a result never appeared
    if (exp_q.size() != 0) num_errors = num_errors + 1;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wait_for(input integer lim, input integer which);
    n = 0;
    do begin
      @(negedge mclk);
      n = n + 1;
    end while ((which == 0 ? r_irq : which == 1 ? halt : sreq) !== 1'b1
      && n < lim);
  endtask
  // look just after the edge, once the new results have settled
  always @(posedge mclk) begin
    #1;
    if (r_irq === 1'b1 && exp_q.size() > 0)
      cmp({r1, rv, r2}, exp_q.pop_front());
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      seed = lfsr(seed);
      {p3, p1, j2, j1} = seed[21:0];
      // bus code kept above the short threshold here
      vb = 10'd559 + seed[27:22];
      wait_for(200, 0);
      exp_q.push_back({j1, vb, j2});
      wait_for(200, 0);
      if (k > 0) cmp(n, 60);
      cmp({s1, s2}, {~p3, ~p1});
    end
    vb = 10'd558;
    wait_for(2000, 1);
    cmp(halt, 1'b1);
    cmp(n >= 200, 1'b1);
    cmp(n <= 280, 1'b1);
    vb = 10'd619;
    repeat (700) @(negedge mclk);
    cmp(sreq, 1'b0);
    vb = 10'd620;
    wait_for(2000, 2);
    cmp(sreq, 1'b1);
    cmp(n >= 500, 1'b1);
    cmp(n <= 580, 1'b1);
    // the requested self reset, then a fresh scan must come through
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    exp_q.push_back({j1, vb, j2});
    @(negedge mclk);
    cmp({halt, sreq, r_irq, start}, 4'h0);
    wait_for(200, 0);
    cmp(r_irq, 1'b1);
    end_of_test;
  end
endmodule // tb_adc_scan_vbus_monitor
